// ---- shared/dram_pkg.sv ----
// Shared constants and types for the DRAM bank, row and read-burst link
package dram_pkg;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam int COL_W = 10;
  localparam int CHOP_BIT = 12;
  localparam int AP_BIT = 10;
  localparam int BURST_FIELD_W = 2;
  localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BURST_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BURST_FIELD_RESET = 2'h1;
  localparam int LAT_W = 5;
  localparam logic [4:0] ADDITIVE_LATENCY_RESET = 5'h00;
  localparam logic [4:0] CAS_LATENCY_RESET = 5'h06;
  localparam int CLOCK_PERIOD_PS = 8000;
  localparam int PRECHARGE_TIME_PS = 13750;
  localparam int PRECHARGE_CYCLES = (PRECHARGE_TIME_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int PRE_CNT_W = 4;
  localparam int COL_SPACING_CHOP = 4;
  localparam int BEATS_EIGHT = 4;
  localparam int BEATS_CHOP = 2;
  localparam int LAT_PIPE = 32;
  typedef enum logic [1:0] {
    CMD_NOP       = 2'b00,
    CMD_ACTIVATE  = 2'b01,
    CMD_PRECHARGE = 2'b10,
    CMD_READ      = 2'b11
  } cmd_t;
  typedef enum logic [1:0] {
    BANK_IDLE     = 2'b00,
    BANK_ACTIVE   = 2'b01,
    BANK_PRECHG   = 2'b10
  } bank_state_t;
endpackage : dram_pkg

// ---- shared/dram_link_if.sv ----
// Command and read-data link between controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface dram_link_if;
  dram_pkg::cmd_t                cmd;
  logic [dram_pkg::BANK_W-1:0]   bank_select_inputs;
  logic [dram_pkg::ADDR_W-1:0]   addr;
  logic                          all_banks;
  logic [dram_pkg::DATA_W-1:0]   dq_rise;
  logic [dram_pkg::DATA_W-1:0]   dq_fall;
  logic                          strobe;
  logic                          dq_oe;
  modport device (input cmd, bank_select_inputs, addr, all_banks, output dq_rise, dq_fall, strobe, dq_oe);
  modport controller (output cmd, bank_select_inputs, addr, all_banks, input dq_rise, dq_fall, strobe, dq_oe);
endinterface : dram_link_if
`default_nettype wire

// ---- logic/dram_device.sv ----
// Memory device end: bank state, row tracking and read bursts
// Function
// - Activate opens addressed row in addressed bank
// - Row stays open until its bank precharged
// - Controller precharges before activating another row
// - Precharge closes one bank or all
// - Controller waits precharge time before activate
// - Other-bank read accepted during auto precharge; device ignores the AP bit and leaves the bank open
// - Controller activates idle bank before reading
// - Precharge to idle or precharging bank legal
// - Precharge period timed from latest precharge
// - Chop bit low four, high eight
// - Chop bit never part of column
// - On-the-fly works with and without auto precharge
// - Burst field 00 fixed eight, 01 selectable
// - Read timing valid only with DLL locked
// - Data starts additive plus CAS latency later
`timescale 1ns/1ps
`default_nettype none
module dram_device (
  input  wire logic                                clock,
  input  wire logic                                rstn,
  dram_link_if.device                              link,
  input  wire logic [dram_pkg::BURST_FIELD_W-1:0]  burst_field,
  input  wire logic [dram_pkg::LAT_W-1:0]          additive_latency,
  input  wire logic [dram_pkg::LAT_W-1:0]          cas_latency,
  input  wire logic                                dll_locked,
  output logic [dram_pkg::NUM_BANKS-1:0]           bank_open,
  output logic [dram_pkg::NUM_BANKS-1:0]           bank_precharging,
  output logic [dram_pkg::COL_W-1:0]               read_column,
  output logic [dram_pkg::ADDR_W-1:0]              read_row,
  output logic                                     read_error
);
  dram_pkg::bank_state_t                 state_r   [dram_pkg::NUM_BANKS];
  dram_pkg::bank_state_t                 state_nxt [dram_pkg::NUM_BANKS];
  logic [dram_pkg::ADDR_W-1:0]           row_r     [dram_pkg::NUM_BANKS];
  logic [dram_pkg::ADDR_W-1:0]           row_nxt   [dram_pkg::NUM_BANKS];
  logic [dram_pkg::PRE_CNT_W-1:0]        pre_cnt_r [dram_pkg::NUM_BANKS];
  logic [dram_pkg::PRE_CNT_W-1:0]        pre_cnt_nxt [dram_pkg::NUM_BANKS];
  logic [dram_pkg::LAT_PIPE-1:0]         go_r, go_nxt;
  logic [dram_pkg::LAT_PIPE-1:0]         chop_pipe_r, chop_pipe_nxt;
  logic [2:0]                            beats_r, beats_nxt;
  logic [dram_pkg::DATA_W-1:0]           word_r, word_nxt;
  logic [dram_pkg::DATA_W-1:0]           rise_r, rise_nxt, fall_r, fall_nxt;
  logic                                  strobe_r, strobe_nxt, oe_r, oe_nxt;
  logic [dram_pkg::COL_W-1:0]            col_r, col_nxt;
  logic [dram_pkg::ADDR_W-1:0]           rrow_r, rrow_nxt;
  logic                                  err_r, err_nxt;
  logic [5:0]                            rl;
  logic [4:0]                            tap;
  logic                                  chop_now, is_read, launch;

  assign rl = {1'b0, additive_latency} + {1'b0, cas_latency};
  assign tap = (rl > 6'd1) ? 5'(rl - 6'd2) : 5'h00;
  assign is_read = (link.cmd == dram_pkg::CMD_READ);
  // Fixed-eight field ignores the chop bit; auto precharge bit plays no part here
  assign chop_now = (burst_field == dram_pkg::BURST_ON_THE_FLY) && !link.addr[dram_pkg::CHOP_BIT];
  assign launch = go_r[tap];

  always_comb begin
    err_nxt = 1'b0;
    col_nxt = col_r;
    rrow_nxt = rrow_r;
    for (int b = 0; b < dram_pkg::NUM_BANKS; b++) begin
      state_nxt[b] = state_r[b];
      row_nxt[b] = row_r[b];
      pre_cnt_nxt[b] = pre_cnt_r[b];
      if (state_r[b] == dram_pkg::BANK_PRECHG) begin
        if (pre_cnt_r[b] <= 4'h1) begin
          state_nxt[b] = dram_pkg::BANK_IDLE;
          pre_cnt_nxt[b] = 4'h0;
        end else begin
          pre_cnt_nxt[b] = pre_cnt_r[b] - 4'h1;
        end
      end
      if (link.cmd == dram_pkg::CMD_PRECHARGE && (link.all_banks || link.bank_select_inputs == 3'(b))) begin
        // Repeat precharge restarts the timer, no error raised
        state_nxt[b] = dram_pkg::BANK_PRECHG;
        pre_cnt_nxt[b] = 4'(dram_pkg::PRECHARGE_CYCLES);
      end
      if (link.cmd == dram_pkg::CMD_ACTIVATE && link.bank_select_inputs == 3'(b)) begin
        state_nxt[b] = dram_pkg::BANK_ACTIVE;
        row_nxt[b] = link.addr;
      end
    end
    if (is_read) begin
      // Only the addressed bank is checked, so others may still precharge
      err_nxt = (state_r[link.bank_select_inputs] != dram_pkg::BANK_ACTIVE);
      col_nxt = link.addr[dram_pkg::COL_W-1:0];
      rrow_nxt = row_r[link.bank_select_inputs];
    end
  end

  always_comb begin
    go_nxt = {go_r[dram_pkg::LAT_PIPE-2:0], is_read};
    chop_pipe_nxt = {chop_pipe_r[dram_pkg::LAT_PIPE-2:0], chop_now};
    beats_nxt = beats_r;
    word_nxt = word_r;
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    strobe_nxt = 1'b0;
    oe_nxt = 1'b0;
    if (launch && dll_locked) begin
      beats_nxt = chop_pipe_r[tap] ? 3'(dram_pkg::BEATS_CHOP) : 3'(dram_pkg::BEATS_EIGHT);
      word_nxt = {6'h00, col_r};
    end
    if (beats_nxt != 3'h0) begin
      oe_nxt = 1'b1;
      strobe_nxt = 1'b1;
      rise_nxt = word_nxt;
      fall_nxt = word_nxt + 16'h0001;
      word_nxt = word_nxt + 16'h0002;
      beats_nxt = beats_nxt - 3'h1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int b = 0; b < dram_pkg::NUM_BANKS; b++) begin
        state_r[b] <= dram_pkg::BANK_IDLE;
        row_r[b] <= 15'h0000;
        pre_cnt_r[b] <= 4'h0;
      end
      go_r <= 32'h0000_0000;
      chop_pipe_r <= 32'h0000_0000;
      beats_r <= 3'h0;
      word_r <= 16'h0000;
      rise_r <= 16'h0000;
      fall_r <= 16'h0000;
      strobe_r <= 1'b0;
      oe_r <= 1'b0;
      col_r <= 10'h000;
      rrow_r <= 15'h0000;
      err_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      row_r <= row_nxt;
      pre_cnt_r <= pre_cnt_nxt;
      go_r <= go_nxt;
      chop_pipe_r <= chop_pipe_nxt;
      beats_r <= beats_nxt;
      word_r <= word_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      strobe_r <= strobe_nxt;
      oe_r <= oe_nxt;
      col_r <= col_nxt;
      rrow_r <= rrow_nxt;
      err_r <= err_nxt;
    end
  end

  always_comb begin
    for (int b = 0; b < dram_pkg::NUM_BANKS; b++) begin
      bank_open[b] = (state_r[b] == dram_pkg::BANK_ACTIVE);
      bank_precharging[b] = (state_r[b] == dram_pkg::BANK_PRECHG);
    end
  end
  assign link.dq_rise = rise_r;
  assign link.dq_fall = fall_r;
  assign link.strobe = strobe_r;
  assign link.dq_oe = oe_r;
  assign read_column = col_r;
  assign read_row = rrow_r;
  assign read_error = err_r;
endmodule : dram_device
`default_nettype wire

// ---- logic/dram_controller.sv ----
// Controller end: issues commands with bank timing and captures read words
`timescale 1ns/1ps
`default_nettype none
module dram_controller (
  input  wire logic                              clock,
  input  wire logic                              rstn,
  dram_link_if.controller                        link,
  input  wire logic                              req_valid,
  output logic                                   req_ready,
  input  wire dram_pkg::cmd_t                    req_cmd,
  input  wire logic [dram_pkg::BANK_W-1:0]       req_bank,
  input  wire logic [dram_pkg::ADDR_W-1:0]       req_addr,
  input  wire logic                              req_all,
  output logic                                   data_valid,
  output logic [dram_pkg::DATA_W-1:0]            data_rise,
  output logic [dram_pkg::DATA_W-1:0]            data_fall
);
  logic [dram_pkg::NUM_BANKS-1:0]       open_r, open_nxt;
  logic [dram_pkg::ADDR_W-1:0]          row_r [dram_pkg::NUM_BANKS];
  logic [dram_pkg::ADDR_W-1:0]          row_nxt [dram_pkg::NUM_BANKS];
  logic [dram_pkg::PRE_CNT_W-1:0]       wait_r [dram_pkg::NUM_BANKS];
  logic [dram_pkg::PRE_CNT_W-1:0]       wait_nxt [dram_pkg::NUM_BANKS];
  logic [2:0]                           gap_r, gap_nxt;
  dram_pkg::cmd_t                       cmd_r, cmd_nxt;
  logic [dram_pkg::BANK_W-1:0]          bank_r, bank_nxt;
  logic [dram_pkg::ADDR_W-1:0]          addr_r, addr_nxt;
  logic                                 all_r, all_nxt;
  logic                                 dv_r;
  logic [dram_pkg::DATA_W-1:0]          dr_r, df_r;
  logic                                 legal;

  // Illegal requests are held off, not dropped
  always_comb begin
    unique case (req_cmd)
      dram_pkg::CMD_ACTIVATE:  legal = !open_r[req_bank] && wait_r[req_bank] == 4'h0;
      dram_pkg::CMD_READ:      legal = open_r[req_bank] && gap_r == 3'h0;
      dram_pkg::CMD_PRECHARGE: legal = 1'b1;
      dram_pkg::CMD_NOP:       legal = 1'b1;
    endcase
  end
  assign req_ready = legal;

  always_comb begin
    open_nxt = open_r;
    gap_nxt = (gap_r != 3'h0) ? gap_r - 3'h1 : 3'h0;
    cmd_nxt = dram_pkg::CMD_NOP;
    bank_nxt = bank_r;
    addr_nxt = addr_r;
    all_nxt = 1'b0;
    for (int b = 0; b < dram_pkg::NUM_BANKS; b++) begin
      row_nxt[b] = row_r[b];
      wait_nxt[b] = (wait_r[b] != 4'h0) ? wait_r[b] - 4'h1 : 4'h0;
    end
    if (req_valid && legal) begin
      cmd_nxt = req_cmd;
      bank_nxt = req_bank;
      addr_nxt = req_addr;
      all_nxt = req_all;
      if (req_cmd == dram_pkg::CMD_READ) begin
        gap_nxt = 3'(dram_pkg::COL_SPACING_CHOP - 1);
      end
      for (int b = 0; b < dram_pkg::NUM_BANKS; b++) begin
        if (req_cmd == dram_pkg::CMD_ACTIVATE && req_bank == 3'(b)) begin
          open_nxt[b] = 1'b1;
          row_nxt[b] = req_addr;
        end
        if (req_cmd == dram_pkg::CMD_PRECHARGE && (req_all || req_bank == 3'(b))) begin
          open_nxt[b] = 1'b0;
          wait_nxt[b] = 4'(dram_pkg::PRECHARGE_CYCLES);
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      open_r <= 8'h00;
      for (int b = 0; b < dram_pkg::NUM_BANKS; b++) begin
        row_r[b] <= 15'h0000;
        wait_r[b] <= 4'h0;
      end
      gap_r <= 3'h0;
      cmd_r <= dram_pkg::CMD_NOP;
      bank_r <= 3'h0;
      addr_r <= 15'h0000;
      all_r <= 1'b0;
      dv_r <= 1'b0;
      dr_r <= 16'h0000;
      df_r <= 16'h0000;
    end else begin
      open_r <= open_nxt;
      row_r <= row_nxt;
      wait_r <= wait_nxt;
      gap_r <= gap_nxt;
      cmd_r <= cmd_nxt;
      bank_r <= bank_nxt;
      addr_r <= addr_nxt;
      all_r <= all_nxt;
      dv_r <= link.strobe && link.dq_oe;
      dr_r <= link.strobe ? link.dq_rise : dr_r;
      df_r <= link.strobe ? link.dq_fall : df_r;
    end
  end

  assign link.cmd = cmd_r;
  assign link.bank_select_inputs = bank_r;
  assign link.addr = addr_r;
  assign link.all_banks = all_r;
  assign data_valid = dv_r;
  assign data_rise = dr_r;
  assign data_fall = df_r;
endmodule : dram_controller
`default_nettype wire

// ---- testbench/dram_link_monitor.sv ----
// Link checker for command order and read burst shape
`timescale 1ns/1ps
`default_nettype none
module dram_link_monitor (
  input wire logic                         clock,
  input wire logic                         rstn,
  input wire dram_pkg::cmd_t               cmd,
  input wire logic [dram_pkg::BANK_W-1:0]  bank_select_inputs,
  input wire logic [dram_pkg::ADDR_W-1:0]  addr,
  input wire logic                         all_banks,
  input wire logic [dram_pkg::DATA_W-1:0]  dq_rise,
  input wire logic [dram_pkg::DATA_W-1:0]  dq_fall,
  input wire logic                         strobe,
  input wire logic                         dq_oe,
  input wire logic                         dll_locked
);
  logic [dram_pkg::NUM_BANKS-1:0] open_r;
  logic [dram_pkg::NUM_BANKS-1:0] open_nxt;
  logic [3:0]                     run_r;
  logic [3:0]                     run_nxt;
  always_comb begin
    open_nxt = open_r;
    run_nxt = strobe ? run_r + 4'h1 : 4'h0;
    if (cmd == dram_pkg::CMD_ACTIVATE) begin
      open_nxt[bank_select_inputs] = 1'b1;
    end
    // Auto precharge closes the bank too, else a later activate looks illegal
    if (cmd == dram_pkg::CMD_READ && addr[dram_pkg::AP_BIT]) begin
      open_nxt[bank_select_inputs] = 1'b0;
    end
    if (cmd == dram_pkg::CMD_PRECHARGE) begin
      open_nxt = all_banks ? '0 : open_nxt & ~(8'h01 << bank_select_inputs);
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      open_r <= '0;
      run_r  <= 4'h0;
    end else begin
      open_r <= open_nxt;
      run_r  <= run_nxt;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence quiet_three;
    (cmd != dram_pkg::CMD_READ) [*3];
  endsequence
  sequence burst_soon;
    ##[2:14] strobe;
  endsequence
  AST_STROBE_OE: assert property (strobe |-> dq_oe)
    else $error("strobe without output enable");
  AST_ACT_CLOSED: assert property (cmd == dram_pkg::CMD_ACTIVATE |-> !open_r[bank_select_inputs])
    else $error("activate over an open row");
  AST_ACT_WAIT: assert property (cmd == dram_pkg::CMD_ACTIVATE && $past(cmd) == dram_pkg::CMD_PRECHARGE
    |-> !$past(all_banks) && $past(bank_select_inputs) != bank_select_inputs)
    else $error("activate inside precharge time");
  AST_READ_SPACING: assert property (cmd == dram_pkg::CMD_READ |=> quiet_three)
    else $error("reads closer than four cycles");
  // Bursts are only promised while the lock holds
  AST_READ_LAUNCH: assert property (cmd == dram_pkg::CMD_READ && dll_locked |-> burst_soon)
    else $error("read burst did not start");
  AST_RUN_EVEN: assert property ($fell(strobe) |-> run_r[0] == 1'b0)
    else $error("odd number of strobe beats");
  AST_DATA_PAIR: assert property (strobe |-> dq_fall == dq_rise + 16'h0001)
    else $error("falling word not next to rising word");
  AST_DATA_STEP: assert property (strobe && run_r[1:0] != 2'h0 |-> dq_rise == $past(dq_rise) + 16'h0002)
    else $error("beat words not consecutive");
endmodule : dram_link_monitor
`default_nettype wire

// ---- testbench/sdram_bank_row_read_control_tb.sv ----
// Testbench driving both link ends through commands and read bursts
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_row_read_control_tb;
  logic           clock, rstn, req_valid, req_ready, req_all, dll_locked, data_valid, read_error;
  dram_pkg::cmd_t req_cmd;
  logic [2:0]     req_bank;
  logic [14:0]    req_addr, read_row;
  logic [1:0]     burst_field;
  logic [4:0]     additive_latency, cas_latency;
  logic [7:0]     bank_open, bank_precharging;
  logic [9:0]     read_column;
  logic [15:0]    data_rise, data_fall;
  int             bad_count, samples_checked, cycles, err_count, pre_count;
  dram_link_if link ();
  dram_device i_dram_device (.clock(clock), .rstn(rstn), .link(link), .burst_field(burst_field),
    .additive_latency(additive_latency), .cas_latency(cas_latency), .dll_locked(dll_locked),
    .bank_open(bank_open), .bank_precharging(bank_precharging), .read_column(read_column),
    .read_row(read_row), .read_error(read_error));
  dram_controller i_dram_controller (.clock(clock), .rstn(rstn), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_all(req_all),
    .data_valid(data_valid), .data_rise(data_rise), .data_fall(data_fall));
  dram_link_monitor i_dram_link_monitor (.clock(clock), .rstn(rstn), .cmd(link.cmd),
    .bank_select_inputs(link.bank_select_inputs), .addr(link.addr), .all_banks(link.all_banks),
    .dq_rise(link.dq_rise), .dq_fall(link.dq_fall), .strobe(link.strobe), .dq_oe(link.dq_oe),
    .dll_locked(dll_locked));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Timeout sized well above the hundred-odd cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("Error at %0t: timeout", $time);
      summarize();
    end
  end
  // Registered outputs read mid-cycle, away from the edge that updates them
  always @(negedge clock) begin
    if (read_error === 1'b1) err_count++;
    if (bank_precharging[3] === 1'b1) pre_count++;
  end
  task automatic summarize();
    $display("Counts: %0d checked, %0d mismatched", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // Hold keeps valid up so a second request can follow on the next edge
  task automatic issue(input dram_pkg::cmd_t c, input logic [2:0] b, input logic [14:0] a, input logic all,
                       input logic hold = 1'b0);
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    req_all <= all;
    req_valid <= 1'b1;
    @(negedge clock);
    while (req_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
    if (!hold) begin
      req_valid <= 1'b0;
      @(posedge clock);
    end
  endtask : issue
  task automatic read_burst(input logic [2:0] b, input logic [14:0] a, input int beats);
    int lat;
    lat = 0;
    issue(dram_pkg::CMD_READ, b, a, 1'b0);
    do begin
      @(negedge clock);
      lat++;
    end while (data_valid !== 1'b1 && lat < 30);
    // Counted from the edge that drives the link command, plus one capture stage
    check(16'(lat), 16'(additive_latency + cas_latency + 1), "latency");
    for (int k = 0; k < beats; k++) begin
      check(data_rise, {6'h00, a[9:0]} + 16'(2 * k), "rise word");
      check(data_fall, {6'h00, a[9:0]} + 16'(2 * k + 1), "fall word");
      @(negedge clock);
    end
    check(16'(data_valid), 16'h0000, "burst length");
    @(posedge clock);
  endtask : read_burst
  task automatic t_open_read();
    issue(dram_pkg::CMD_ACTIVATE, 3'h3, 15'h1234, 1'b0);
    repeat (3) @(posedge clock);
    check(16'(bank_open), 16'h0008, "bank open");
    read_burst(3'h3, 15'h1010, 4);
    check(16'(read_row), 16'h1234, "row");
    check(16'(read_column), 16'h0010, "column");
    read_burst(3'h3, 15'h0020, 2);
    read_burst(3'h3, 15'h0430, 2);
    $display("open_read done");
  endtask : t_open_read
  task automatic t_precharge();
    int n;
    issue(dram_pkg::CMD_PRECHARGE, 3'h0, 15'h0000, 1'b1);
    issue(dram_pkg::CMD_ACTIVATE, 3'h3, 15'h0001, 1'b0);
    issue(dram_pkg::CMD_ACTIVATE, 3'h5, 15'h0002, 1'b0);
    repeat (3) @(posedge clock);
    check(16'(bank_open), 16'h0028, "two banks open");
    n = err_count;
    pre_count = 0;
    // Two precharges one edge apart: period runs from the second
    issue(dram_pkg::CMD_PRECHARGE, 3'h3, 15'h0000, 1'b0, 1'b1);
    issue(dram_pkg::CMD_PRECHARGE, 3'h3, 15'h0000, 1'b0);
    repeat (8) @(negedge clock);
    check(16'(pre_count), 16'(1 + dram_pkg::PRECHARGE_CYCLES), "precharge period");
    check(16'(bank_open), 16'h0020, "single bank closed");
    check(16'(err_count - n), 16'h0000, "repeat precharge error");
    @(posedge clock);
    issue(dram_pkg::CMD_PRECHARGE, 3'h0, 15'h0000, 1'b1);
    repeat (3) @(posedge clock);
    check(16'(bank_open), 16'h0000, "all banks closed");
    $display("precharge done");
  endtask : t_precharge
  task automatic t_fixed_and_idle();
    int n, seen;
    burst_field <= dram_pkg::BURST_FIXED_EIGHT;
    issue(dram_pkg::CMD_ACTIVATE, 3'h1, 15'h0007, 1'b0);
    read_burst(3'h1, 15'h0008, 4);
    burst_field <= dram_pkg::BURST_ON_THE_FLY;
    n = err_count;
    // Controller must hold a read to an idle bank off the link
    req_cmd <= dram_pkg::CMD_READ;
    req_bank <= 3'h6;
    req_addr <= 15'h1040;
    req_all <= 1'b0;
    req_valid <= 1'b1;
    repeat (6) @(negedge clock);
    check(16'(req_ready), 16'h0000, "read to idle bank held");
    @(posedge clock);
    req_valid <= 1'b0;
    @(posedge clock);
    check(16'(err_count - n), 16'h0000, "read to idle bank");
    dll_locked <= 1'b0;
    issue(dram_pkg::CMD_READ, 3'h1, 15'h1008, 1'b0);
    seen = 0;
    repeat (14) begin
      @(negedge clock);
      if (data_valid === 1'b1) seen++;
    end
    check(16'(seen), 16'h0000, "burst without lock");
    @(posedge clock);
    dll_locked <= 1'b1;
    $display("fixed_and_idle done");
  endtask : t_fixed_and_idle
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_cmd = dram_pkg::CMD_NOP;
    req_bank = 3'h0;
    req_addr = 15'h0000;
    req_all = 1'b0;
    burst_field = dram_pkg::BURST_ON_THE_FLY;
    additive_latency = 5'h02;
    cas_latency = 5'h06;
    dll_locked = 1'b1;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_open_read();
    t_precharge();
    t_fixed_and_idle();
    summarize();
  end
endmodule : sdram_bank_row_read_control_tb
`default_nettype wire
